// >>> hdl/asr_pkg.sv
// Package of constants and types for the asynchronous serial receiver.
package asr_pkg;

  // ****************************************************************
  // Register map, byte addresses on the 32-bit bus.
  // ****************************************************************
  localparam logic [7:0] ASR_OFS_RATE_CONTROL = 8'h00;
  localparam logic [7:0] ASR_OFS_INTERRUPT_CONTROL = 8'h04;
  localparam logic [7:0] ASR_OFS_PERIPHERAL_ENABLES_ONE = 8'h08;
  localparam logic [7:0] ASR_OFS_PERIPHERAL_FLAGS_ONE = 8'h0C;
  localparam logic [7:0] ASR_OFS_RECEIVE_CONTROL_STATUS = 8'h10;
  localparam logic [7:0] ASR_OFS_RATE_DIVISOR_LOW = 8'h14;
  localparam logic [7:0] ASR_OFS_RATE_DIVISOR_HIGH = 8'h18;
  localparam logic [7:0] ASR_OFS_PORT_C_DIRECTION = 8'h1C;
  localparam logic [7:0] ASR_OFS_TRANSMIT_HOLDING = 8'h20;
  localparam logic [7:0] ASR_OFS_TRANSMIT_CONTROL_STATUS = 8'h24;
  localparam logic [7:0] ASR_OFS_RX_HOLDING = 8'h28;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int ASR_BIT_SERIAL_PORT_ENABLE = 7;
  localparam int ASR_BIT_NINE_BIT_RECEIVE = 6;
  localparam int ASR_BIT_CONT_RECEIVE_ENABLE = 4;
  localparam int ASR_BIT_STOP_BIT_FAULT = 2;
  localparam int ASR_BIT_FIFO_OVERFLOW_FAULT = 1;
  localparam int ASR_BIT_RECEIVED_BIT8 = 0;
  localparam int ASR_BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int ASR_BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int ASR_BIT_RX_IRQ_ENABLE = 5;
  localparam int ASR_BIT_RX_PENDING_FLAG = 5;
  localparam int ASR_BIT_CLOCKED_MODE_SELECT = 4;
  localparam int ASR_BIT_WIDE_DIVISOR = 3;
  // Control bits that software may write in receive_control_status.
  localparam logic [7:0] ASR_RCS_WRITE_MASK = 8'hF8;
  // Control bits that software may write in rate_control.
  localparam logic [7:0] ASR_RATE_WRITE_MASK = 8'h1B;

  // ****************************************************************
  // Reset values and timing counts.
  // ****************************************************************
  localparam logic [7:0] ASR_RESET_BYTE = 8'h00;
  localparam logic [7:0] ASR_RESET_DIRECTION = 8'hFF;
  localparam logic [7:0] ASR_RESET_TX_STATUS = 8'h02;
  localparam int ASR_TICKS_PER_BIT = 16;
  localparam int ASR_TICKS_TO_MID = ASR_TICKS_PER_BIT / 2;
  localparam int ASR_QUEUE_DEPTH = 2;

  // One queued character with its own stop-bit fault.
  typedef struct packed {
    logic stop_bit_fault;
    logic bit8;
    logic [7:0] data;
  } asr_entry_t;

  // Receiver states, Gray coded along idle, start, data, stop.
  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_START = 2'b01,
    ASR_DATA = 2'b11,
    ASR_STOP = 2'b10
  } asr_state_t;

endpackage

// >>> hdl/asr_receiver.sv
// Asynchronous serial receiver with two-character queue and bus slave.
// What this block does
// - Recovery runs at sixteen ticks per bit; shifter moves once per bit.
// - A finished 8 or 9 bit character moves whole into a two-entry queue.
// - Receiver works only with receive enable, async mode and port enable.
// - A character begins on a falling edge of the input while idle.
// - Half a bit after the edge the line must still be low.
// - A high mid-start sample silently drops the character and resumes.
// - Each later bit is taken one bit period on, by majority vote.
// - Stop bit sampled one bit later; low sets the fault, high clears it.
// - After the stop bit the character is queued; the pending flag rises.
// - Reading the holding register returns the oldest entry and pops it.
// - Pending flag is high while enabled and queue holds data; read-only.
// - Interrupt request needs all three enables; the flag ignores them.
// - Each entry keeps its stop fault; status shows the oldest entry.
// - Stop fault: read-only, cleared by port off, kept by receive off.
// - A stop fault neither halts reception nor raises an interrupt.
// - A third whole character with both entries unread sets overflow.
// - While overflowed no character enters; queued ones stay readable.
// - Overflow clears only on receive disable or port disable.
// - Nine-bit mode shifts 9 bits; bit 8 of the oldest entry is shown.
// - Data bits arrive least significant first; first becomes bit 0.
`timescale 1ns/1ps

module asr_receiver
  import asr_pkg::*;
(
  input wire logic ref_clk, // System clock, 10 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Write when high.
  input wire logic [7:0] wb_adr_i, // Byte address.
  input wire logic [3:0] wb_sel_i, // Byte lane selects.
  input wire logic [31:0] wb_dat_i, // Write data.
  output logic [31:0] wb_dat_o, // Read data.
  output logic wb_ack_o, // Cycle acknowledge.
  input wire logic serial_in_pin, // Serial line from the far transmitter.
  output logic rx_pending_flag, // Unread character waiting.
  output logic rx_irq_req // Gated receive interrupt request.
);

  // ****************************************************************
  // State declarations.
  // ****************************************************************
  logic [7:0] rate_control_reg, rate_control_next;
  logic [7:0] interrupt_control_reg, interrupt_control_next;
  logic [7:0] peripheral_enables_one_reg, peripheral_enables_one_next;
  logic [7:0] receive_control_status_reg, receive_control_status_next;
  logic [7:0] rate_divisor_low_reg, rate_divisor_low_next;
  logic [7:0] rate_divisor_high_reg, rate_divisor_high_next;
  logic [7:0] port_c_direction_reg, port_c_direction_next;
  logic [7:0] transmit_holding_reg, transmit_holding_next;
  logic [7:0] transmit_control_status_reg, transmit_control_status_next;
  logic [31:0] wb_dat_reg, wb_dat_next;
  logic wb_ack_reg, wb_ack_next;
  logic line_meta_reg, line_sync_reg, line_prev_reg;
  logic [15:0] div_cnt_reg, div_cnt_next;
  logic tick_reg, tick_next;
  asr_state_t state_reg, state_next;
  logic [3:0] tick_cnt_reg, tick_cnt_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [8:0] rx_shift_register_reg, rx_shift_register_next;
  logic [1:0] hist_reg, hist_next;
  asr_entry_t queue_reg [ASR_QUEUE_DEPTH];
  asr_entry_t queue_next [ASR_QUEUE_DEPTH];
  logic [1:0] count_reg, count_next;
  logic overflow_reg, overflow_next;
  logic pending_reg, pending_next;
  logic irq_reg, irq_next;

  // ****************************************************************
  // Decoded controls and strobes.
  // ****************************************************************
  logic port_on, rx_on, nine_bits, bus_req, wr_en, rd_pop;
  logic majority, push, pop;
  logic [15:0] divisor;
  asr_entry_t new_entry;
  logic [3:0] last_bit;

  // The receiver runs only with all three control bits in place.
  assign port_on = receive_control_status_reg[ASR_BIT_SERIAL_PORT_ENABLE];
  assign rx_on = port_on
    & receive_control_status_reg[ASR_BIT_CONT_RECEIVE_ENABLE]
    & ~transmit_control_status_reg[ASR_BIT_CLOCKED_MODE_SELECT];
  assign nine_bits = receive_control_status_reg[ASR_BIT_NINE_BIT_RECEIVE];
  assign last_bit = nine_bits ? 4'h8 : 4'h7;

  // A request is served in the cycle after it is seen, once per cycle.
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
  assign rd_pop = bus_req & ~wb_we_i
    & (wb_adr_i == ASR_OFS_RX_HOLDING);

  // Divisor width follows the wide-divisor bit, as for the transmitter.
  assign divisor = rate_control_reg[ASR_BIT_WIDE_DIVISOR]
    ? {rate_divisor_high_reg, rate_divisor_low_reg}
    : {8'h00, rate_divisor_low_reg};

  // Two earlier tick samples and the present one vote on the bit.
  assign majority = (hist_reg[1] & hist_reg[0])
    | (hist_reg[1] & line_sync_reg)
    | (hist_reg[0] & line_sync_reg);

  // ****************************************************************
  // Input synchroniser.
  // ****************************************************************
  // The first stage feeds only the second; the line idles high.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_meta_reg <= 1'b1;
      line_sync_reg <= 1'b1;
      line_prev_reg <= 1'b1;
    end else begin
      line_meta_reg <= serial_in_pin;
      line_sync_reg <= line_meta_reg;
      line_prev_reg <= line_sync_reg;
    end
  end

  // ****************************************************************
  // Sixteen-times tick generator.
  // ****************************************************************
  // One tick every divisor plus one clocks; held at zero while the port
  // is off so that the first tick after enabling is a full period.
  always_comb begin
    div_cnt_next = div_cnt_reg;
    tick_next = 1'b0;
    if (!port_on) begin
      div_cnt_next = 16'h0000;
    end else if (div_cnt_reg >= divisor) begin
      div_cnt_next = 16'h0000;
      tick_next = 1'b1;
    end else begin
      div_cnt_next = div_cnt_reg + 16'h0001;
    end
  end

  // ****************************************************************
  // Bit recovery state machine.
  // ****************************************************************
  // The counter runs on ticks; the shift register moves once per bit.
  always_comb begin
    state_next = state_reg;
    tick_cnt_next = tick_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_shift_register_next = rx_shift_register_reg;
    hist_next = hist_reg;
    push = 1'b0;
    new_entry = '0;
    new_entry.data = rx_shift_register_reg[7:0];
    new_entry.bit8 = nine_bits & rx_shift_register_reg[8];
    new_entry.stop_bit_fault = ~majority;
    if (tick_reg) begin
      hist_next = {hist_reg[0], line_sync_reg};
    end
    if (!rx_on) begin
      state_next = ASR_IDLE;
      tick_cnt_next = 4'h0;
    end else begin
      unique case (state_reg)
        ASR_IDLE: begin
          // Overflow holds off any new character until it is cleared.
          if (line_prev_reg & ~line_sync_reg & ~overflow_reg) begin
            state_next = ASR_START;
            tick_cnt_next = 4'h0;
          end
        end
        ASR_START: begin
          if (tick_reg) begin
            tick_cnt_next = tick_cnt_reg + 4'h1;
            if (tick_cnt_reg == 4'(ASR_TICKS_TO_MID - 1)) begin
              tick_cnt_next = 4'h0;
              bit_cnt_next = 4'h0;
              // A high middle means a glitch; no fault is raised.
              state_next = line_sync_reg ? ASR_IDLE : ASR_DATA;
            end
          end
        end
        ASR_DATA: begin
          if (tick_reg) begin
            tick_cnt_next = tick_cnt_reg + 4'h1;
            if (tick_cnt_reg == 4'(ASR_TICKS_PER_BIT - 1)) begin
              // Right shift places the first bit at bit 0 once full.
              if (nine_bits) begin
                rx_shift_register_next =
                  {majority, rx_shift_register_reg[8:1]};
              end else begin
                rx_shift_register_next =
                  {1'b0, majority, rx_shift_register_reg[7:1]};
              end
              bit_cnt_next = bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == last_bit) begin
                state_next = ASR_STOP;
              end
            end
          end
        end
        ASR_STOP: begin
          if (tick_reg) begin
            tick_cnt_next = tick_cnt_reg + 4'h1;
            if (tick_cnt_reg == 4'(ASR_TICKS_PER_BIT - 1)) begin
              // A bad stop bit still delivers the character.
              push = 1'b1;
              state_next = ASR_IDLE;
              tick_cnt_next = 4'h0;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Receive queue and fault flags.
  // ****************************************************************
  // A push and a pop in one cycle both take effect, so no character and
  // no overflow event is lost when software reads at that moment.
  always_comb begin
    queue_next = queue_reg;
    count_next = count_reg;
    overflow_next = overflow_reg;
    pop = rd_pop & (count_reg != 2'd0);
    if (pop) begin
      queue_next[0] = queue_reg[1];
      count_next = count_reg - 2'd1;
    end
    if (push) begin
      if (count_reg == 2'(ASR_QUEUE_DEPTH) && !pop) begin
        overflow_next = 1'b1;
      end else begin
        queue_next[count_next[0]] = new_entry;
        count_next = count_next + 2'd1;
      end
    end
    if (!receive_control_status_reg[ASR_BIT_CONT_RECEIVE_ENABLE]) begin
      overflow_next = 1'b0;
    end
    if (!port_on) begin
      // Port disable empties the queue and clears overflow and the queued stop faults.
      overflow_next = 1'b0;
      count_next = 2'd0;
      queue_next[0] = '0;
      queue_next[1] = '0;
    end
  end

  // Flag and request follow the queue; software cannot touch either.
  always_comb begin
    pending_next = rx_on & (count_next != 2'd0);
    // Only the pending flag drives the request, never a stop fault.
    irq_next = pending_next
      & peripheral_enables_one_reg[ASR_BIT_RX_IRQ_ENABLE]
      & interrupt_control_reg[ASR_BIT_PERIPHERAL_IRQ_ENABLE]
      & interrupt_control_reg[ASR_BIT_GLOBAL_IRQ_ENABLE];
  end

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  // Only byte lane zero carries data; status bits ignore writes.
  always_comb begin
    rate_control_next = rate_control_reg;
    interrupt_control_next = interrupt_control_reg;
    peripheral_enables_one_next = peripheral_enables_one_reg;
    receive_control_status_next = receive_control_status_reg;
    rate_divisor_low_next = rate_divisor_low_reg;
    rate_divisor_high_next = rate_divisor_high_reg;
    port_c_direction_next = port_c_direction_reg;
    transmit_holding_next = transmit_holding_reg;
    transmit_control_status_next = transmit_control_status_reg;
    if (wr_en) begin
      unique case (wb_adr_i)
        ASR_OFS_RATE_CONTROL:
          rate_control_next = wb_dat_i[7:0] & ASR_RATE_WRITE_MASK;
        ASR_OFS_INTERRUPT_CONTROL:
          interrupt_control_next = wb_dat_i[7:0];
        ASR_OFS_PERIPHERAL_ENABLES_ONE:
          peripheral_enables_one_next = wb_dat_i[7:0];
        ASR_OFS_RECEIVE_CONTROL_STATUS:
          receive_control_status_next =
            wb_dat_i[7:0] & ASR_RCS_WRITE_MASK;
        ASR_OFS_RATE_DIVISOR_LOW:
          rate_divisor_low_next = wb_dat_i[7:0];
        ASR_OFS_RATE_DIVISOR_HIGH:
          rate_divisor_high_next = wb_dat_i[7:0];
        ASR_OFS_PORT_C_DIRECTION:
          port_c_direction_next = wb_dat_i[7:0];
        ASR_OFS_TRANSMIT_HOLDING:
          transmit_holding_next = wb_dat_i[7:0];
        ASR_OFS_TRANSMIT_CONTROL_STATUS:
          // The empty-shifter bit stays set; there is no transmitter.
          transmit_control_status_next = wb_dat_i[7:0] | ASR_RESET_TX_STATUS;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Register reads and acknowledge.
  // ****************************************************************
  // Every address is answered; unmapped and write-only ones read zero.
  always_comb begin
    wb_ack_next = bus_req;
    wb_dat_next = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ASR_OFS_RATE_CONTROL:
          wb_dat_next[7:0] = rate_control_reg;
        ASR_OFS_INTERRUPT_CONTROL:
          wb_dat_next[7:0] = interrupt_control_reg;
        ASR_OFS_PERIPHERAL_ENABLES_ONE:
          wb_dat_next[7:0] = peripheral_enables_one_reg;
        ASR_OFS_PERIPHERAL_FLAGS_ONE:
          wb_dat_next[ASR_BIT_RX_PENDING_FLAG] = pending_reg;
        ASR_OFS_RECEIVE_CONTROL_STATUS: begin
          wb_dat_next[7:0] = receive_control_status_reg;
          wb_dat_next[ASR_BIT_STOP_BIT_FAULT] =
            queue_reg[0].stop_bit_fault;
          wb_dat_next[ASR_BIT_FIFO_OVERFLOW_FAULT] = overflow_reg;
          wb_dat_next[ASR_BIT_RECEIVED_BIT8] = queue_reg[0].bit8;
        end
        ASR_OFS_RATE_DIVISOR_LOW:
          wb_dat_next[7:0] = rate_divisor_low_reg;
        ASR_OFS_RATE_DIVISOR_HIGH:
          wb_dat_next[7:0] = rate_divisor_high_reg;
        ASR_OFS_PORT_C_DIRECTION:
          wb_dat_next[7:0] = port_c_direction_reg;
        ASR_OFS_TRANSMIT_CONTROL_STATUS:
          wb_dat_next[7:0] = transmit_control_status_reg;
        ASR_OFS_RX_HOLDING:
          wb_dat_next[7:0] = queue_reg[0].data;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // State registers.
  // ****************************************************************
  // All control state is constant under reset and follows _next after.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_control_reg <= ASR_RESET_BYTE;
      interrupt_control_reg <= ASR_RESET_BYTE;
      peripheral_enables_one_reg <= ASR_RESET_BYTE;
      receive_control_status_reg <= ASR_RESET_BYTE;
      rate_divisor_low_reg <= ASR_RESET_BYTE;
      rate_divisor_high_reg <= ASR_RESET_BYTE;
      port_c_direction_reg <= ASR_RESET_DIRECTION;
      transmit_holding_reg <= ASR_RESET_BYTE;
      transmit_control_status_reg <= ASR_RESET_TX_STATUS;
      wb_dat_reg <= 32'h0000_0000;
      wb_ack_reg <= 1'b0;
      div_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
      state_reg <= ASR_IDLE;
      tick_cnt_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      rx_shift_register_reg <= 9'h000;
      hist_reg <= 2'b11;
      queue_reg[0] <= '0;
      queue_reg[1] <= '0;
      count_reg <= 2'd0;
      overflow_reg <= 1'b0;
      pending_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      rate_control_reg <= rate_control_next;
      interrupt_control_reg <= interrupt_control_next;
      peripheral_enables_one_reg <= peripheral_enables_one_next;
      receive_control_status_reg <= receive_control_status_next;
      rate_divisor_low_reg <= rate_divisor_low_next;
      rate_divisor_high_reg <= rate_divisor_high_next;
      port_c_direction_reg <= port_c_direction_next;
      transmit_holding_reg <= transmit_holding_next;
      transmit_control_status_reg <= transmit_control_status_next;
      wb_dat_reg <= wb_dat_next;
      wb_ack_reg <= wb_ack_next;
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_shift_register_reg <= rx_shift_register_next;
      hist_reg <= hist_next;
      queue_reg <= queue_next;
      count_reg <= count_next;
      overflow_reg <= overflow_next;
      pending_reg <= pending_next;
      irq_reg <= irq_next;
    end
  end

  // ****************************************************************
  // Outputs, each straight from a flip-flop.
  // ****************************************************************
  assign wb_dat_o = wb_dat_reg;
  assign wb_ack_o = wb_ack_reg;
  assign rx_pending_flag = pending_reg;
  assign rx_irq_req = irq_reg;

endmodule

// >>> sim/asr_line_tx.sv
// Model of the far transmitter that drives the receive line.
`timescale 1ns/1ps
module asr_line_tx #(
  parameter int BIT_CLKS = 64 // Clocks per bit time.
) (
  input wire logic ref_clk, // Paces the bit times.
  output logic line_o // Serial line; idles high as a mark.
);
  initial line_o = 1'b1;
  // Holds one level for a whole bit time.
  task automatic put(input logic b);
    line_o <= b;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask
  // A frame, then one idle bit so a low stop still leaves a clean
  // falling edge for the next start.
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    put(1'b0);
    for (int i = 0; i < n; i++) begin
      put(d[i]);
    end
    put(stp);
    put(1'b1);
  endtask
  // Noise: a low pulse that ends well before the middle of a start bit.
  task automatic glitch();
    line_o <= 1'b0;
    repeat (12) @(posedge ref_clk);
    put(1'b1);
  endtask
endmodule

// >>> sim/asr_monitor.sv
// Checker for the receiver's bus and receive-flag ports.
`timescale 1ns/1ps
module asr_monitor (
  input wire logic ref_clk, // Clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic rx_pending_flag, // Unread character waiting.
  input wire logic rx_irq_req // Gated interrupt request.
);
  // ****************************************************************
  // Port checks, all in the one clock domain, quiet during reset.
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // The answer comes one cycle after the request is taken.
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  chk_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data off ack");
  chk_dat_upper: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper data");
  // Flag and request are registered together, so the request never
  // stands without the flag, not even in the cycle in which both rise.
  chk_irq_gate: assert property (
    rx_irq_req |-> rx_pending_flag)
    else $error("request without flag");
  chk_irq_rise: assert property (
    $rose(rx_irq_req) |-> rx_pending_flag)
    else $error("request rose without a queued character");
  // Only a bus access (a pop or a disable) can take the flag away.
  chk_flag_fall: assert property (
    $fell(rx_pending_flag) |->
      $past(wb_cyc_i) || $past(wb_cyc_i, 2) || $past(wb_cyc_i, 3))
    else $error("flag fell without bus access");
endmodule
bind asr_receiver asr_monitor mon_u (.ref_clk(ref_clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_pending_flag(rx_pending_flag),
  .rx_irq_req(rx_irq_req));

// >>> sim/tb_top.sv
// Self-checking bench for the asynchronous serial receiver.
`timescale 1ns/1ps
module tb_top;
  import asr_pkg::*;
  logic ref_clk, reset_n, cyc, stb, we, ack, ser, pend, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int err_total, checks_done;
  asr_receiver dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .serial_in_pin(ser),
    .rx_pending_flag(pend), .rx_irq_req(irq));
  // Divisor 3 gives a tick every 4 clocks, so 64 clocks a bit.
  asr_line_tx #(.BIT_CLKS(64)) tx_u (.ref_clk(ref_clk), .line_o(ser));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle; waits for ack, a hang is ended by the watchdog.
  task automatic wb(input logic w, input logic [7:0] a, d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge ref_clk);
    // The acknowledge stands for one cycle only.
    check("ack drop", ack, 1'b0);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, e);
    wb(1'b0, a, 8'h00);
    check(nm, q, {24'h0, e});
  endtask
  task automatic s_reset();
    rd("dir", ASR_OFS_PORT_C_DIRECTION, ASR_RESET_DIRECTION);
    wb(1'b1, ASR_OFS_PORT_C_DIRECTION, 8'hFF);
    rd("txs", ASR_OFS_TRANSMIT_CONTROL_STATUS, ASR_RESET_TX_STATUS);
    rd("rcs", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h00);
    rd("unmapped", 8'h2C, 8'h00);
    wb(1'b1, ASR_OFS_PERIPHERAL_FLAGS_ONE, 8'hFF);
    rd("flags", ASR_OFS_PERIPHERAL_FLAGS_ONE, 8'h00);
    wb(1'b1, ASR_OFS_RATE_DIVISOR_LOW, 8'h03);
    wb(1'b1, ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h80);
    tx_u.send(9'h055, 8, 1'b1);
    check("off pend", pend, 1'b0);
    wb(1'b1, ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h90);
  endtask
  // Good frame, then a bad-stop frame queued ahead of a good one.
  task automatic s_frames();
    tx_u.send(9'h0A5, 8, 1'b1);
    check("pend", pend, 1'b1);
    rd("rcs", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h90);
    rd("hold", ASR_OFS_RX_HOLDING, 8'hA5);
    tx_u.send(9'h03C, 8, 1'b0);
    tx_u.send(9'h081, 8, 1'b1);
    rd("rcs f", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h94);
    rd("hold f", ASR_OFS_RX_HOLDING, 8'h3C);
    rd("rcs g", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h90);
    rd("hold g", ASR_OFS_RX_HOLDING, 8'h81);
    tx_u.glitch();
    tx_u.send(9'h05A, 8, 1'b1);
    rd("hold n", ASR_OFS_RX_HOLDING, 8'h5A);
    rd("rcs n", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h90);
    check("pend n", pend, 1'b0);
  endtask
  // Three whole characters into two places, then one more while stuck.
  task automatic s_overflow();
    tx_u.send(9'h011, 8, 1'b1);
    tx_u.send(9'h022, 8, 1'b1);
    tx_u.send(9'h033, 8, 1'b1);
    rd("ovf", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h92);
    tx_u.send(9'h044, 8, 1'b1);
    rd("q0", ASR_OFS_RX_HOLDING, 8'h11);
    rd("q1", ASR_OFS_RX_HOLDING, 8'h22);
    rd("ovf k", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h92);
    check("pend o", pend, 1'b0);
    wb(1'b1, ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h80);
    wb(1'b1, ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h90);
    rd("ovf c", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h90);
    wb(1'b1, ASR_OFS_RECEIVE_CONTROL_STATUS, 8'hD0);
    tx_u.send(9'h1F0, 9, 1'b1);
    rd("bit8", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'hD1);
    rd("hold9", ASR_OFS_RX_HOLDING, 8'hF0);
  endtask
  // Request gating, then a port disable clearing fault and queue.
  task automatic s_irq();
    wb(1'b1, ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h90);
    wb(1'b1, ASR_OFS_INTERRUPT_CONTROL, 8'hC0);
    wb(1'b1, ASR_OFS_PERIPHERAL_ENABLES_ONE, 8'h20);
    tx_u.send(9'h0C3, 8, 1'b0);
    check("irq", irq, 1'b1);
    wb(1'b1, ASR_OFS_INTERRUPT_CONTROL, 8'h40);
    rd("flags", ASR_OFS_PERIPHERAL_FLAGS_ONE, 8'h20);
    check("irq off", irq, 1'b0);
    wb(1'b1, ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h10);
    rd("serial_port_enable", ASR_OFS_RECEIVE_CONTROL_STATUS, 8'h10);
    check("pend s", pend, 1'b0);
  endtask
  task automatic wrap_up();
    $display("Checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Whole run is near 8000 clocks; the watchdog allows about six times.
  initial begin
    repeat (50000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end
  initial begin
    reset_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'hF; wdat = 32'h0; err_total = 0; checks_done = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    s_reset();
    s_frames();
    s_overflow();
    s_irq();
    wrap_up();
  end
endmodule
